// file: rtl/bpf_pkg.sv
// Constants for the two-cell protection state machine.
// Assumes a 40 MHz core clock.
package bpf_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  // Nominal delays in microseconds
  localparam int unsigned OVC_DET_US   = 1_000_000;
  localparam int unsigned OVC_REL_US   = 40_000;
  localparam int unsigned OVD_DET_US   = 100_000;
  localparam int unsigned OVD_REL_US   = 1_000;
  localparam int unsigned OCUR_DET_US  = 20_000;
  localparam int unsigned OCUR_REL_US  = 1_000;
  localparam int unsigned XCHG_DET_US  = 1_500;
  localparam int unsigned XCHG_REL_US  = 1_500;
  // Short-circuit delay in nanoseconds (not shortened by test pin)
  localparam int unsigned SHORT_DET_NS = 250_000;
  localparam int unsigned CNT_W        = 26;
  localparam int unsigned SHORTEN_SH   = 6;
  function automatic logic [CNT_W-1:0] us_cycles(input longint unsigned us);
    longint unsigned c;
    c = (us * CLK_HZ) / 1_000_000;
    if (c == 0)
      c = 1;
    return c[CNT_W-1:0];
  endfunction
  localparam logic [CNT_W-1:0] SHORT_DET_CYC =
    CNT_W'((longint'(SHORT_DET_NS) * CLK_HZ) / 1_000_000_000);
endpackage

// file: rtl/bpf_protect.sv
// Protection state machine for a two-cell lithium-ion pack.
// Assumes comparator results arrive asynchronously from the analog front end.
`timescale 1ns/1ps
module bpf_protect
  import bpf_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Cell comparators
  input  wire logic cell_hi_ovc,
  input  wire logic cell_lo_ovc,
  input  wire logic cell_hi_ovc_rel,
  input  wire logic cell_lo_ovc_rel,
  input  wire logic cell_hi_ovd,
  input  wire logic cell_lo_ovd,
  // Sense node comparators
  input  wire logic sense_ocur,
  input  wire logic sense_short,
  input  wire logic sense_xchg,
  input  wire logic sense_stby_rel,
  input  wire logic load_present,
  // Test pin
  input  wire logic delay_shorten,
  // Gate outputs
  output logic      charge_gate,
  output logic      discharge_gate,
  // Sense node pulls and status
  output logic      supply_side_pull,
  output logic      ground_side_pull,
  output logic      reduced_hyst,
  output logic      standby
);

  localparam int unsigned NIN = 12;

  // Synchroniser bit positions
  localparam int unsigned IN_HI_OVC     = 11;
  localparam int unsigned IN_LO_OVC     = 10;
  localparam int unsigned IN_HI_OVC_REL = 9;
  localparam int unsigned IN_LO_OVC_REL = 8;
  localparam int unsigned IN_HI_OVD     = 7;
  localparam int unsigned IN_LO_OVD     = 6;
  localparam int unsigned IN_OCUR       = 5;
  localparam int unsigned IN_SHORT      = 4;
  localparam int unsigned IN_XCHG       = 3;
  localparam int unsigned IN_STBY_REL   = 2;
  localparam int unsigned IN_LOAD       = 1;
  localparam int unsigned IN_SHORTEN    = 0;

  typedef enum logic [2:0] {
    CNT_IDLE,
    CNT_RUN,
    CNT_DONE
  } bpf_cnt_t;

  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  logic           ovc_any;
  logic           ovc_rel_all;
  logic           ovd_any;
  logic           ovd_clear_all;
  logic           ocur;
  logic           shrt;
  logic           xchg;
  logic           stby_rel;
  logic           load;
  logic           shorten;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1[IN_HI_OVC]     <= cell_hi_ovc;
      sync1[IN_LO_OVC]     <= cell_lo_ovc;
      sync1[IN_HI_OVC_REL] <= cell_hi_ovc_rel;
      sync1[IN_LO_OVC_REL] <= cell_lo_ovc_rel;
      sync1[IN_HI_OVD]     <= cell_hi_ovd;
      sync1[IN_LO_OVD]     <= cell_lo_ovd;
      sync1[IN_OCUR]       <= sense_ocur;
      sync1[IN_SHORT]      <= sense_short;
      sync1[IN_XCHG]       <= sense_xchg;
      sync1[IN_STBY_REL]   <= sense_stby_rel;
      sync1[IN_LOAD]       <= load_present;
      sync1[IN_SHORTEN]    <= delay_shorten;
      sync2                <= sync1;
    end
  end

  always_comb
  begin
    ovc_any       = sync2[IN_HI_OVC] | sync2[IN_LO_OVC];
    ovc_rel_all   = sync2[IN_HI_OVC_REL] & sync2[IN_LO_OVC_REL];
    ovd_any       = sync2[IN_HI_OVD] | sync2[IN_LO_OVD];
    ovd_clear_all = ~(sync2[IN_HI_OVD] | sync2[IN_LO_OVD]);
    ocur          = sync2[IN_OCUR];
    shrt          = sync2[IN_SHORT];
    xchg          = sync2[IN_XCHG];
    stby_rel      = sync2[IN_STBY_REL];
    load          = sync2[IN_LOAD];
    shorten       = sync2[IN_SHORTEN];
  end

  // Detection states
  logic ovc_st;
  logic ovd_st;
  logic ocur_st;
  logic xchg_st;
  logic stby_st;

  // Delay target, shortened in test mode
  function automatic logic [CNT_W-1:0] tgt(input logic [CNT_W-1:0] full,
                                           input logic sh);
    logic [CNT_W-1:0] t;
    t = sh ? (full >> SHORTEN_SH) : full;
    if (t == '0)
      t = CNT_W'(1);
    return t;
  endfunction

  // Qualifying conditions for each timed event
  logic c_ovc_det;
  logic c_ovc_rel;
  logic c_ovd_det;
  logic c_ovd_rel;
  logic c_oc_det;
  logic c_oc_rel;
  logic c_x_det;
  logic c_x_rel;
  logic c_sc_det;
  logic monitor;

  always_comb
  begin
    monitor   = ~stby_st;
    c_ovc_det = monitor & ~ovc_st & ovc_any;
    c_ovc_rel = monitor & ovc_st & ovc_rel_all
                & (~ocur | load);
    c_ovd_det = monitor & ~ovd_st & ovd_any & ~ovc_st;
    c_ovd_rel = monitor & ovd_st & ovd_clear_all;
    c_oc_det  = monitor & ~ocur_st & ~ovc_st & ~ovd_st & ocur;
    c_sc_det  = monitor & ~ocur_st & ~ovd_st & shrt;
    c_oc_rel  = ocur_st & ~ocur;
    c_x_det   = monitor & ~xchg_st & ~ovc_st & ~ovd_st
                & discharge_gate & xchg;
    c_x_rel   = xchg_st & ~xchg;
  end

  // One restartable counter per event
  localparam int unsigned NEV = 9;

  // Event slots
  localparam int unsigned EV_OVC_DET = 0;
  localparam int unsigned EV_OVC_REL = 1;
  localparam int unsigned EV_OVD_DET = 2;
  localparam int unsigned EV_OVD_REL = 3;
  localparam int unsigned EV_OC_DET  = 4;
  localparam int unsigned EV_OC_REL  = 5;
  localparam int unsigned EV_X_DET   = 6;
  localparam int unsigned EV_X_REL   = 7;
  localparam int unsigned EV_SC_DET  = 8;

  logic [NEV-1:0]   cond;
  logic [NEV-1:0]   fire;
  logic [CNT_W-1:0] lim      [NEV];
  logic [CNT_W-1:0] cnt      [NEV];
  logic [CNT_W-1:0] next_cnt [NEV];

  // Counter next values
  always_comb
  begin
    for (int i = 0; i < NEV; i++)
      next_cnt[i] = cnt[i] + CNT_W'(1);
  end

  always_comb
  begin
    cond[EV_OVC_DET] = c_ovc_det;
    cond[EV_OVC_REL] = c_ovc_rel;
    cond[EV_OVD_DET] = c_ovd_det;
    cond[EV_OVD_REL] = c_ovd_rel;
    cond[EV_OC_DET]  = c_oc_det;
    cond[EV_OC_REL]  = c_oc_rel;
    cond[EV_X_DET]   = c_x_det;
    cond[EV_X_REL]   = c_x_rel;
    cond[EV_SC_DET]  = c_sc_det;
    lim[EV_OVC_DET] = tgt(us_cycles(OVC_DET_US), shorten);
    lim[EV_OVC_REL] = tgt(us_cycles(OVC_REL_US), shorten);
    lim[EV_OVD_DET] = tgt(us_cycles(OVD_DET_US), shorten);
    lim[EV_OVD_REL] = tgt(us_cycles(OVD_REL_US), shorten);
    lim[EV_OC_DET]  = tgt(us_cycles(OCUR_DET_US), shorten);
    lim[EV_OC_REL]  = tgt(us_cycles(OCUR_REL_US), shorten);
    lim[EV_X_DET]   = tgt(us_cycles(XCHG_DET_US), shorten);
    lim[EV_X_REL]   = tgt(us_cycles(XCHG_REL_US), shorten);
    lim[EV_SC_DET]  = (SHORT_DET_CYC == '0) ? CNT_W'(1) : SHORT_DET_CYC;
    for (int i = 0; i < NEV; i++)
      fire[i] = cond[i] & (next_cnt[i] >= lim[i]);
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NEV; i++)
    begin
      if (sys_rst || !cond[i] || fire[i])
        cnt[i] <= '0;
      else
        cnt[i] <= next_cnt[i];
    end
  end

  // Over-charge state
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ovc_st <= 1'b0;
    else if (fire[EV_OVC_DET])
      ovc_st <= 1'b1;
    else if (fire[EV_OVC_REL])
      ovc_st <= 1'b0;
  end

  // Reduced hysteresis once a load appears during over-charge
  always_ff @(posedge clk)
  begin
    if (sys_rst || !ovc_st)
      reduced_hyst <= 1'b0;
    else if (load)
      reduced_hyst <= 1'b1;
  end

  // Over-discharge state
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ovd_st <= 1'b0;
    else if (fire[EV_OVD_DET])
      ovd_st <= 1'b1;
    else if (fire[EV_OVD_REL])
      ovd_st <= 1'b0;
  end

  // Standby entry on over-discharge, exit via charger
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      stby_st <= 1'b0;
    else if (fire[EV_OVD_DET])
      stby_st <= 1'b1;
    else if (stby_st && stby_rel)
      stby_st <= 1'b0;
  end

  // Over-current or short-circuit state; cleared when over-discharge takes over
  always_ff @(posedge clk)
  begin
    if (sys_rst || fire[EV_OVD_DET])
      ocur_st <= 1'b0;
    else if (fire[EV_OC_DET] || fire[EV_SC_DET])
      ocur_st <= 1'b1;
    else if (fire[EV_OC_REL])
      ocur_st <= 1'b0;
  end

  // Excess-charger state
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      xchg_st <= 1'b0;
    else if (fire[EV_X_DET])
      xchg_st <= 1'b1;
    else if (fire[EV_X_REL])
      xchg_st <= 1'b0;
  end

  // Registered outputs
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      charge_gate <= 1'b1;
    else
      charge_gate <= ~(ovc_st | xchg_st);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      discharge_gate <= 1'b1;
    else
      discharge_gate <= ~(ovd_st | ocur_st);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      supply_side_pull <= 1'b0;
    else
      supply_side_pull <= ovd_st;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ground_side_pull <= 1'b0;
    else
      ground_side_pull <= ocur_st & ~ovd_st;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      standby <= 1'b0;
    else
      standby <= stby_st;
  end

endmodule

// file: tb/bpf_pack.sv
// Pack model: cells, charger and load seen as comparator levels.
// Assumes the bench sets the wanted conditions on cmd.
`timescale 1ns/1ps
module bpf_pack (
  // Clock and wanted conditions
  input  wire logic        clk,
  input  wire logic [10:0] cmd,
  // Comparator levels
  output logic      [10:0] lvl
);
  // Levels settle one cycle after a change
  always_ff @(posedge clk)
  begin
    lvl <= cmd;
  end
endmodule

// file: tb/bpf_protect_assertions.sv
// Checker for the protection state machine outputs.
// Assumes binding to the top module ports.
`timescale 1ns/1ps
module bpf_protect_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Comparators
  input wire logic cell_hi_ovc,
  input wire logic cell_lo_ovc,
  input wire logic cell_hi_ovd,
  input wire logic cell_lo_ovd,
  input wire logic sense_ocur,
  input wire logic sense_short,
  input wire logic sense_xchg,
  input wire logic sense_stby_rel,
  // Outputs
  input wire logic charge_gate,
  input wire logic discharge_gate,
  input wire logic supply_side_pull,
  input wire logic ground_side_pull,
  input wire logic standby,
  input wire logic reduced_hyst
);
  wire dg_cause = cell_hi_ovd | cell_lo_ovd | sense_ocur | sense_short;
  wire dg_hold  = cell_hi_ovd | cell_lo_ovd | sense_ocur;
  wire cg_cause = cell_hi_ovc | cell_lo_ovc | sense_xchg;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_state:
    assert property (disable iff (1'b0) sys_rst |=> charge_gate && discharge_gate
      && !supply_side_pull && !ground_side_pull && !standby) else $error("bad reset");
  a_pull_exclusive:
    assert property (!(supply_side_pull && ground_side_pull)) else $error("both pulls");
  a_standby_pull:
    assert property (standby |-> supply_side_pull && !discharge_gate) else $error("standby");
  a_dgate_fall:
    assert property ($fell(discharge_gate) |-> $past(dg_cause, 5)) else $error("dgate fall");
  a_cgate_fall:
    assert property ($fell(charge_gate) |-> $past(cg_cause, 5)) else $error("cgate fall");
  a_ground_pull:
    assert property ($rose(ground_side_pull) |-> !discharge_gate) else $error("gnd pull");
  a_dgate_rise:
    assert property ($rose(discharge_gate) |-> !$past(dg_hold, 5)) else $error("dgate rise");
  a_standby_exit:
    assert property ($fell(standby) |-> $past(sense_stby_rel, 4)) else $error("stby exit");
  a_hyst_overcharge:
    assert property (reduced_hyst |-> !charge_gate) else $error("hyst outside over-charge");
endmodule
bind bpf_protect bpf_protect_assertions chk_i (.*);

// file: tb/bpf_protect_tb.sv
// Bench for the protection state machine.
// Assumes shortened delays; a pack model drives the comparators.
`timescale 1ns/1ps
module bpf_protect_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [10:0] cmd = 11'h00c;
  wire  [10:0] lvl;
  wire  [4:0]  o;
  wire         hyst;
  logic [4:0]  o_q = 5'h18;
  logic [4:0]  exq[$];
  int          loq[$];
  int          cyc = 0;
  int          err_total = 0;
  int          n_checks = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  bpf_pack pack (.clk(clk), .cmd(cmd), .lvl(lvl));
  bpf_protect DUT (
    .clk(clk), .sys_rst(sys_rst),
    .cell_hi_ovc(lvl[0]), .cell_lo_ovc(lvl[1]),
    .cell_hi_ovc_rel(lvl[2]), .cell_lo_ovc_rel(lvl[3]),
    .cell_hi_ovd(lvl[4]), .cell_lo_ovd(lvl[5]),
    .sense_ocur(lvl[6]), .sense_short(lvl[7]), .sense_xchg(lvl[8]),
    .sense_stby_rel(lvl[9]), .load_present(lvl[10]),
    .delay_shorten(1'b1),
    .charge_gate(o[4]), .discharge_gate(o[3]), .supply_side_pull(o[2]),
    .ground_side_pull(o[1]), .reduced_hyst(hyst), .standby(o[0]));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Drive a condition, note the outcome, wait for it
  task automatic step(input logic [10:0] c, input logic [4:0] e, input int n);
    @(posedge clk) #2;
    cmd = c;
    exq.push_back(e);
    loq.push_back(cyc + n);
    wait (exq.size() == 0);
  endtask
  // Compare each settled output change with the oldest note
  always @(negedge clk)
    if (!sys_rst && o !== o_q)
    begin
      if (exq.size() == 0)
        chk(o, o_q);
      else
      begin
        chk(cyc >= loq[0] && cyc <= loq[0] + 12, 1);
        repeat (3) @(negedge clk);
        chk(o, exq[0]);
        void'(exq.pop_front());
        void'(loq.pop_front());
      end
      o_q = o;
    end
  initial
  begin
    repeat (100000) @(posedge clk);
    err_total++;
    results();
  end
  initial
  begin
    void'($urandom(32'hc0e7));
    repeat (3) @(posedge clk);
    #2 sys_rst = 1'b0;
    @(posedge clk) #2;
    chk(o, 5'h18);
    step(11'h44c, 5'h12, 12500);
    step(11'h40c, 5'h18, 625);
    step(11'h4cc, 5'h12, 10000);
    step(11'h40c, 5'h18, 625);
    @(posedge clk) #2;
    cmd = 11'h50c;
    repeat ($urandom_range(800, 100)) @(posedge clk);
    #2 cmd = 11'h40c;
    repeat (1200) @(posedge clk);
    step(11'h50c, 5'h08, 937);
    step(11'h40c, 5'h18, 937);
    step(11'h42c, 5'h15, 62500);
    step(11'h62c, 5'h14, 0);
    step(11'h60c, 5'h18, 625);
    chk(hyst, 1'b0);
    results();
  end
endmodule
